// file: rtl/afalu_core.sv
`default_nettype none
module afalu_core
  import afalu_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  afalu_state_t st_reg;
  afalu_state_t st_next;

  function automatic afalu_flags_t afalu_szp(input logic [7:0] res, input logic ac,
                                             input logic c);
    afalu_flags_t f;
    f.s  = res[7];
    f.z  = (res == 8'h00);
    f.p  = ~^res;
    f.ac = ac;
    f.c  = c;
    return f;
  endfunction : afalu_szp

  function automatic logic [7:0] afalu_flag_byte(input afalu_flags_t f);
    logic [7:0] b;
    b = 8'h00;
    b[FLAG_S_POS]  = f.s;
    b[FLAG_Z_POS]  = f.z;
    b[FLAG_AC_POS] = f.ac;
    b[FLAG_P_POS]  = f.p;
    b[FLAG_C_POS]  = f.c;
    return b;
  endfunction : afalu_flag_byte

  function automatic afalu_state_t afalu_exec(input afalu_state_t st, input afalu_cmd_t cmd);
    afalu_state_t q;
    logic [7:0]   a;
    logic [7:0]   r;
    logic [7:0]   res;
    logic [8:0]   sum;
    logic [4:0]   lo;
    logic         cond;
    q    = st;
    a    = st.regs[ACC_IDX];
    r    = st.regs[cmd.sel];
    res  = 8'h00;
    sum  = 9'h000;
    lo   = 5'h00;
    cond = 1'b0;
    // All fields land in one state copy, so a branch next sees them
    unique case (cmd.op)
      OP_AND: begin
        res = a & st.opnd;
        q.regs[ACC_IDX] = res;
        q.flags = afalu_szp(res, 1'b0, 1'b0);
      end
      OP_OR: begin
        res = a | st.opnd;
        q.regs[ACC_IDX] = res;
        q.flags = afalu_szp(res, 1'b0, 1'b0);
      end
      OP_XOR: begin
        res = a ^ st.opnd;
        q.regs[ACC_IDX] = res;
        q.flags = afalu_szp(res, 1'b0, 1'b0);
      end
      OP_ADD: begin
        sum = {1'b0, a} + {1'b0, st.opnd};
        lo  = {1'b0, a[3:0]} + {1'b0, st.opnd[3:0]};
        q.regs[ACC_IDX] = sum[7:0];
        q.flags = afalu_szp(sum[7:0], lo[4], sum[8]);
      end
      OP_RAR: begin
        q.regs[ACC_IDX] = {st.flags.c, a[7:1]};
        q.flags.c = a[0];
      end
      OP_RAL: begin
        q.regs[ACC_IDX] = {a[6:0], st.flags.c};
        q.flags.c = a[7];
      end
      OP_CMC: q.flags.c = ~st.flags.c;
      OP_STC: q.flags.c = 1'b1;
      OP_INR: begin
        res = r + 8'h01;
        q.regs[cmd.sel] = res;
        q.flags = afalu_szp(res, (r[3:0] == 4'hF), st.flags.c);
      end
      OP_DCR: begin
        res = r - 8'h01;
        q.regs[cmd.sel] = res;
        // Borrow seen as carry of adding all ones to the low digit
        q.flags = afalu_szp(res, (r[3:0] != 4'h0), st.flags.c);
      end
      OP_CMA: q.regs[ACC_IDX] = ~a;
      OP_DAA: begin
        sum = {1'b0, a};
        lo  = {1'b0, a[3:0]};
        if ((a[3:0] > DEC_LIMIT) || st.flags.ac) begin
          sum = sum + ADJ_LO;
          lo  = lo + 5'h06;
        end
        if ((sum[7:4] > DEC_LIMIT) || st.flags.c) begin
          sum = sum + ADJ_HI;
        end
        q.regs[ACC_IDX] = sum[7:0];
        q.flags = afalu_szp(sum[7:0], lo[4], sum[8] | st.flags.c);
      end
      OP_BRANCH: begin
        // Only four flags are decodable; auxiliary carry has no code
        unique case (cmd.sel[1:0])
          2'd0: cond = st.flags.c;
          2'd1: cond = st.flags.z;
          2'd2: cond = st.flags.s;
          2'd3: cond = st.flags.p;
        endcase
        q.taken = (cond == cmd.sense);
        q.pc    = (cond == cmd.sense) ? st.target : st.pc + BRANCH_LEN;
      end
      default: q = st;
    endcase
    return q;
  endfunction : afalu_exec

  function automatic logic afalu_hit(input logic [7:0] addr);
    return (addr[1:0] == 2'b00) &&
           ((addr[7:5] == REGWIN_SEL) || (addr == CMD_OFS) || (addr == OPND_OFS) ||
            (addr == FLAGS_OFS) || (addr == TARGET_OFS) || (addr == PC_OFS) ||
            (addr == STATUS_OFS) || (addr == MADDR_OFS));
  endfunction : afalu_hit

  function automatic logic [31:0] afalu_read(input afalu_state_t st, input logic [7:0] addr);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (addr[7:5] == REGWIN_SEL) begin
      d[7:0] = st.regs[addr[4:2]];
    end else begin
      unique case (addr)
        CMD_OFS:    d[7:0]  = st.cmd;
        OPND_OFS:   d[7:0]  = st.opnd;
        FLAGS_OFS:  d[7:0]  = afalu_flag_byte(st.flags);
        TARGET_OFS: d[15:0] = st.target;
        PC_OFS:     d[15:0] = st.pc;
        STATUS_OFS: d[0]    = st.taken;
        MADDR_OFS:  d[15:0] = {st.regs[H_IDX], st.regs[L_IDX]};
        default:    d = 32'h0000_0000;
      endcase
    end
    return d;
  endfunction : afalu_read

  always_comb begin
    st_next = st_reg;
    // Answer is prepared in setup, so access always ends in one cycle
    st_next.pready  = psel & ~penable;
    st_next.pslverr = psel & ~penable & ~afalu_hit(paddr);
    st_next.prdata  = 32'h0000_0000;
    if (psel && !penable && !pwrite && afalu_hit(paddr)) begin
      st_next.prdata = afalu_read(st_reg, paddr);
    end
    if (psel && penable && st_reg.pready && pwrite && !st_reg.pslverr) begin
      if (paddr[7:5] == REGWIN_SEL) begin
        st_next.regs[paddr[4:2]] = pwdata[7:0];
      end else begin
        unique case (paddr)
          CMD_OFS: begin
            st_next     = afalu_exec(st_reg, afalu_cmd_t'(pwdata[7:0]));
            st_next.cmd = afalu_cmd_t'(pwdata[7:0]);
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
            st_next.prdata  = 32'h0000_0000;
          end
          OPND_OFS: st_next.opnd = pwdata[7:0];
          FLAGS_OFS: begin
            st_next.flags.s  = pwdata[FLAG_S_POS];
            st_next.flags.z  = pwdata[FLAG_Z_POS];
            st_next.flags.ac = pwdata[FLAG_AC_POS];
            st_next.flags.p  = pwdata[FLAG_P_POS];
            st_next.flags.c  = pwdata[FLAG_C_POS];
          end
          TARGET_OFS: st_next.target = pwdata[15:0];
          PC_OFS:     st_next.pc     = pwdata[15:0];
          default:    st_next.pc     = st_reg.pc;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg         <= '0;
      st_reg.regs    <= {8{REG_RST}};
      st_reg.pc      <= PC_RST;
      st_reg.cmd.op  <= OP_NOP;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata  = st_reg.prdata;
  assign pready  = st_reg.pready;
  assign pslverr = st_reg.pslverr;

endmodule : afalu_core
`default_nettype wire

// file: pkg/afalu_pkg.sv
`default_nettype none
package afalu_pkg;
  // Byte addresses of the APB register map
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] OPND_OFS   = 8'h04;
  localparam logic [7:0] FLAGS_OFS  = 8'h08;
  localparam logic [7:0] TARGET_OFS = 8'h0C;
  localparam logic [7:0] PC_OFS     = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] MADDR_OFS  = 8'h18;
  localparam logic [2:0] REGWIN_SEL = 3'h1;
  // Register bank indices
  localparam logic [2:0] H_IDX   = 3'h4;
  localparam logic [2:0] L_IDX   = 3'h5;
  localparam logic [2:0] ACC_IDX = 3'h7;
  // Flag positions in the flags word
  localparam int FLAG_S_POS  = 7;
  localparam int FLAG_Z_POS  = 6;
  localparam int FLAG_AC_POS = 4;
  localparam int FLAG_P_POS  = 2;
  localparam int FLAG_C_POS  = 0;
  // Reset values and constants
  localparam logic [7:0]  REG_RST    = 8'h00;
  localparam logic [15:0] PC_RST     = 16'h0000;
  localparam logic [15:0] BRANCH_LEN = 16'h0003;
  localparam logic [3:0]  DEC_LIMIT  = 4'h9;
  localparam logic [8:0]  ADJ_LO     = 9'h006;
  localparam logic [8:0]  ADJ_HI     = 9'h060;

  typedef enum logic [3:0] {
    OP_NOP, OP_AND, OP_OR, OP_XOR, OP_ADD, OP_RAR, OP_RAL, OP_CMC,
    OP_STC, OP_INR, OP_DCR, OP_CMA, OP_DAA, OP_BRANCH
  } afalu_op_t;

  typedef struct packed {
    logic      sense;
    logic [2:0] sel;
    afalu_op_t op;
  } afalu_cmd_t;

  typedef struct packed {
    logic s;
    logic z;
    logic ac;
    logic p;
    logic c;
  } afalu_flags_t;

  typedef struct packed {
    logic [7:0][7:0] regs;
    afalu_flags_t    flags;
    afalu_cmd_t      cmd;
    logic [7:0]      opnd;
    logic [15:0]     target;
    logic [15:0]     pc;
    logic            taken;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
  } afalu_state_t;
endpackage : afalu_pkg
`default_nettype wire

// file: testbench/afalu_checker.sv
`default_nettype none
module afalu_checker
  import afalu_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ans; psel && !penable |=> pready; endproperty
  property p_in; pready |-> psel && penable; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  property p_algn; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr; endproperty
  property p_stat; pready && !pwrite && paddr == STATUS_OFS |-> prdata[31:1] == 31'h0;
  endproperty
  property p_flg; pready && !pwrite && paddr == FLAGS_OFS |-> prdata[31:8] == 24'h0;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  a_in: assert property (p_in) else $error("answer outside access");
  a_one: assert property (p_one) else $error("answer too long");
  a_err: assert property (p_err) else $error("error without answer");
  a_idle: assert property (p_idle) else $error("read data not idle");
  a_algn: assert property (p_algn) else $error("unaligned not refused");
  a_stat: assert property (p_stat) else $error("status upper bits set");
  a_flg: assert property (p_flg) else $error("flags upper bits set");
  c_wr: cover property (pready && pwrite);
  c_rd: cover property (pready && !pwrite);
  c_er: cover property (pslverr);
endmodule : afalu_checker
bind afalu_core afalu_checker afalu_checker_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));
`default_nettype wire

// file: testbench/testbench.sv
`default_nettype none
module testbench
  import afalu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] q;
  logic        e;
  int          fail_count = 0;
  int          checks_done = 0;
  initial begin
    forever #4 pclk = ~pclk;
  end
  afalu_core afalu_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string n);
    xfer(1'b0, a, 32'h0);
    chk(n, q, x);
  endtask : rdc
  // Load accumulator or register, operand and flags, run one op, read back
  task automatic alu(input logic [2:0] s, input logic [7:0] v, input logic [7:0] o,
    input logic [7:0] f, input afalu_op_t op, input logic [7:0] ev, input logic [7:0] ef);
    xfer(1'b1, 8'h20 + {3'h0, s, 2'h0}, {24'h0, v});
    xfer(1'b1, OPND_OFS, {24'h0, o});
    xfer(1'b1, FLAGS_OFS, {24'h0, f});
    xfer(1'b1, CMD_OFS, {24'h0, 1'b0, s, op});
    rdc(8'h20 + {3'h0, s, 2'h0}, {24'h0, ev}, "result");
    rdc(FLAGS_OFS, {24'h0, ef}, "flags");
  endtask : alu
  task automatic br(input logic [2:0] s, input logic sn, input logic [15:0] pc, input logic t);
    xfer(1'b1, CMD_OFS, {24'h0, sn, s, OP_BRANCH});
    rdc(PC_OFS, {16'h0, pc}, "pc");
    rdc(STATUS_OFS, {31'h0, t}, "taken");
  endtask : br
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(FLAGS_OFS, 32'h0, "rst flags");
    rdc(PC_OFS, 32'h0, "rst pc");
    alu(3'h7, 8'hB2, 8'hDF, 8'h11, OP_AND, 8'h92, 8'h80);
    alu(3'h7, 8'hB2, 8'hDF, 8'h01, OP_OR, 8'hFF, 8'h84);
    alu(3'h7, 8'hB2, 8'hDF, 8'h01, OP_XOR, 8'h6D, 8'h00);
    alu(3'h7, 8'h49, 8'hB7, 8'h00, OP_ADD, 8'h00, 8'h55);
    alu(3'h7, 8'h01, 8'h01, 8'h01, OP_ADD, 8'h02, 8'h00);
    alu(3'h7, 8'h81, 8'h00, 8'h00, OP_RAR, 8'h40, 8'h01);
    alu(3'h7, 8'h40, 8'h00, 8'h01, OP_RAL, 8'h81, 8'h00);
    alu(3'h7, 8'h80, 8'h00, 8'h00, OP_RAL, 8'h00, 8'h01);
    alu(3'h7, 8'h00, 8'h00, 8'hD4, OP_CMC, 8'h00, 8'hD5);
    alu(3'h7, 8'h00, 8'h00, 8'hD5, OP_CMC, 8'h00, 8'hD4);
    alu(3'h7, 8'h00, 8'h00, 8'hD4, OP_STC, 8'h00, 8'hD5);
    alu(3'h7, 8'hA8, 8'h00, 8'hD4, OP_CMA, 8'h57, 8'hD4);
    alu(3'h7, 8'h33, 8'h00, 8'hD5, OP_NOP, 8'h33, 8'hD5);
    alu(3'h0, 8'hFF, 8'h00, 8'h01, OP_INR, 8'h00, 8'h55);
    alu(3'h6, 8'h7F, 8'h00, 8'h01, OP_INR, 8'h80, 8'h91);
    alu(3'h2, 8'h01, 8'h00, 8'h01, OP_DCR, 8'h00, 8'h55);
    alu(3'h2, 8'h00, 8'h00, 8'h00, OP_DCR, 8'hFF, 8'h84);
    alu(3'h7, 8'h9B, 8'h00, 8'h00, OP_DAA, 8'h01, 8'h11);
    alu(3'h7, 8'h12, 8'h00, 8'h01, OP_DAA, 8'h72, 8'h05);
    alu(3'h7, 8'h12, 8'h00, 8'h10, OP_DAA, 8'h18, 8'h04);
    xfer(1'b1, TARGET_OFS, 32'h1234);
    xfer(1'b1, PC_OFS, 32'h0100);
    xfer(1'b1, FLAGS_OFS, 32'h01);
    rdc(TARGET_OFS, 32'h1234, "target");
    xfer(1'b1, 8'h30, 32'h12);
    xfer(1'b1, 8'h34, 32'h34);
    rdc(MADDR_OFS, 32'h1234, "mem pointer");
    br(3'h0, 1'b1, 16'h1234, 1'b1);
    br(3'h1, 1'b1, 16'h1237, 1'b0);
    br(3'h1, 1'b0, 16'h1234, 1'b1);
    xfer(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
